// [bench/ctr_checker.sv]
// port assertions for the up/down counter bank
// assumes it is bound to updown_counter_bank and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ctr_checker (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // counter outputs
   input wire [3:0] cmp_out,
   input wire [3:0] irq_req,
   // register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // handshake steps
   // ----------------------------------------
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   endsequence
   sequence s_wr_answer;
      s_axi_awready && s_axi_wready && s_axi_bvalid ##1 !s_axi_awready && !s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   endsequence
   sequence s_rd_answer;
      s_axi_arready && s_axi_rvalid ##1 !s_axi_arready;
   endsequence
   property p_wr_answer;
      s_wr_taken |=> s_wr_answer;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered next cycle");
   property p_rd_answer;
      s_rd_taken |=> s_rd_answer;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
   property p_no_aw_pending;
      s_axi_bvalid && $past(s_axi_bvalid) |-> !s_axi_awready;
   endproperty
   a_no_aw_pending: assert property (p_no_aw_pending) else $error("write taken while busy");
   property p_no_ar_pending;
      s_axi_rvalid && $past(s_axi_rvalid) |-> !s_axi_arready;
   endproperty
   a_no_ar_pending: assert property (p_no_ar_pending) else $error("read taken while busy");
   property p_irq_pulse;
      (irq_req & $past(irq_req)) == 4'h0;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt request longer than one cycle");
   property p_rst_quiet;
      $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && irq_req == 4'h0 && cmp_out == 4'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   c_irq: cover property (irq_req != 4'h0);
endmodule
`default_nettype wire

// [bench/field_pins.sv]
// field side model: count pulses, hardware gate and latch pin
// assumes the bank samples these pins through its own synchronisers
`timescale 1ns/1ps
`default_nettype none
module field_pins (
   // clock
   input wire logic clk,
   // pins toward the bank
   output logic [3:0] count_up_pin,
   output logic [3:0] count_down_pin,
   output logic hw_gate_pin,
   output logic latch_pin
);
   initial begin
      count_up_pin = 4'h0;
      count_down_pin = 4'h0;
      hw_gate_pin = 1'b0;
      latch_pin = 1'b0;
   end
   // kind 0 up, 1 down, 2 latch; each level held two cycles or more
   task automatic step(input int kind, input int k);
      @(posedge clk);
      if (kind == 0) count_up_pin[k] <= 1'b1;
      else if (kind == 1) count_down_pin[k] <= 1'b1;
      else latch_pin <= 1'b1;
      repeat (2) @(posedge clk);
      count_up_pin <= 4'h0;
      count_down_pin <= 4'h0;
      latch_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // a rising gate edge restarts after an automatic close
   task automatic gate(input logic v);
      @(posedge clk);
      hw_gate_pin <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the up/down counter bank
// assumes the field pin model and the checker are compiled beside it
`timescale 1ns/1ps
`include "updown_counter_regs.vh"
`default_nettype none
module testbench;
   localparam logic [31:0] GATE = 32'h1 << `CTRL_SW_GATE;
   localparam logic [31:0] ONCE = 32'(`MODE_ONCE) << `CTRL_MODE_LO;
   localparam logic [31:0] PER = 32'(`MODE_PERIOD) << `CTRL_MODE_LO;
   localparam logic [31:0] FWD = 32'(`DIR_FWD) << `CTRL_DIR_LO;
   localparam logic [31:0] BWD = 32'(`DIR_BWD) << `CTRL_DIR_LO;
   localparam logic [31:0] ABRT = 32'h1 << `CTRL_ABORT;
   localparam logic [31:0] HWEN = 32'h1 << `CTRL_HW_EN;
   localparam logic [31:0] IOU = (32'h1 << `CTRL_IE_OVF) | (32'h1 << `CTRL_IE_UNF);
   localparam logic [31:0] IHWO = 32'h1 << `CTRL_IE_HWO;
   localparam logic [31:0] CGE = 32'(`CMP_GE) << `CTRL_CMP_LO;
   logic clk, rst_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire logic [3:0] up_pin, down_pin, cmp_out, irq_req;
   wire logic gate_pin, latch_pin;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int n_fail, checks, cyc;
   logic [7:0] irq_cnt [4] = '{default: 8'h00};
   field_pins pins (.clk(clk), .count_up_pin(up_pin), .count_down_pin(down_pin),
      .hw_gate_pin(gate_pin), .latch_pin(latch_pin));
   updown_counter_bank DUT (.clk(clk), .rst_n(rst_n), .count_up_pin(up_pin),
      .count_down_pin(down_pin), .hw_gate_pin(gate_pin), .latch_pin(latch_pin),
      .cmp_out(cmp_out), .irq_req(irq_req), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++) if (irq_req[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 8'h01;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // bus tasks and compare
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] ad(input int c, input logic [7:0] off);
      return 8'(c * 32) + off;
   endfunction
   task automatic wreg(input int c, input logic [7:0] off, input logic [31:0] d);
      logic [1:0] r;
      wr(ad(c, off), d, r);
   endtask
   task automatic rreg(input int c, input logic [7:0] off, input logic [31:0] exp,
      input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] d;
      logic [1:0] r;
      rd(ad(c, off), d, r);
      chk(d & m, exp);
   endtask
   // closed then open, so the gate sees a rising edge
   task automatic arm(input int c, input logic [31:0] ctl, input logic [31:0] ld, input logic [31:0] ev);
      wreg(c, `OFF_LOAD, ld);
      wreg(c, `OFF_END, ev);
      wreg(c, `OFF_CTRL, ctl & ~GATE);
      wreg(c, `OFF_CTRL, ctl);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_bus();
      logic [31:0] d;
      logic [1:0] r;
      rreg(0, `OFF_END, `END_RST);
      rreg(3, `OFF_STATUS, 32'h0);
      rreg(3, `OFF_LATCH - 8'h60, 32'h0);
      rd(8'h18, d, r);
      chk(32'(r), 32'(`RESP_SLVERR));
      wr(`OFF_LATCH, 32'h5, r);
      chk(32'(r), 32'(`RESP_SLVERR));
   endtask
   task automatic t_cont();
      arm(0, GATE | ABRT | IOU, `LIMIT_MAX, `END_RST);
      pins.step(0, 0);
      rreg(0, `OFF_COUNT, `LIMIT_MIN);
      rreg(0, `OFF_STATUS, 32'h9);
      chk(32'(irq_cnt[0]), 32'h1);
      wreg(0, `OFF_STATUS, 32'h1);
      pins.step(1, 0);
      rreg(0, `OFF_COUNT, `LIMIT_MAX);
      rreg(0, `OFF_STATUS, 32'hA);
   endtask
   task automatic t_once_period();
      arm(1, GATE | ONCE | ABRT, `LIMIT_MAX, `END_RST);
      pins.step(0, 1);
      pins.step(0, 1);
      rreg(1, `OFF_COUNT, `LIMIT_MIN);
      rreg(1, `OFF_STATUS, 32'h11);
      arm(1, GATE | ONCE, 32'h0, `END_RST);
      pins.step(0, 1);
      rreg(1, `OFF_COUNT, 32'h80000001);
      arm(1, GATE | PER | ABRT, 32'h7FFFFFFE, `END_RST);
      pins.step(0, 1);
      pins.step(0, 1);
      rreg(1, `OFF_COUNT, 32'h7FFFFFFE);
   endtask
   task automatic t_dir();
      wreg(2, `OFF_CMP, 32'h6);
      arm(2, GATE | PER | FWD | ABRT | CGE, 32'h5, 32'h7);
      pins.step(0, 2);
      chk(32'(cmp_out[2]), 32'h1);
      pins.step(0, 2);
      rreg(2, `OFF_COUNT, 32'h5);
      chk(32'(cmp_out[2]), 32'h0);
      arm(2, GATE | ONCE | FWD | ABRT, 32'h5, 32'h7);
      pins.step(0, 2);
      pins.step(0, 2);
      pins.step(0, 2);
      rreg(2, `OFF_COUNT, 32'h5);
      rreg(2, `OFF_STATUS, 32'h10, 32'h18);
      arm(2, GATE | PER | BWD | ABRT, 32'h5, 32'h3);
      pins.step(1, 2);
      pins.step(1, 2);
      rreg(2, `OFF_COUNT, 32'h5);
      arm(2, GATE | PER | FWD | ABRT, `LIMIT_MIN, 32'h7);
      pins.step(1, 2);
      rreg(2, `OFF_COUNT, `LIMIT_MAX);
   endtask
   task automatic t_gate();
      arm(0, GATE | ABRT | HWEN, 32'hA, `END_RST);
      pins.step(0, 0);
      rreg(0, `OFF_COUNT, 32'hB);
      wreg(0, `OFF_CTRL, 32'h0);
      pins.step(0, 0);
      rreg(0, `OFF_COUNT, 32'hB);
      wreg(0, `OFF_CTRL, GATE);
      pins.step(0, 0);
      rreg(0, `OFF_COUNT, 32'hC);
      arm(0, GATE | ABRT, 32'hA, `END_RST);
      rreg(0, `OFF_COUNT, 32'hA);
   endtask
   task automatic t_ctr3();
      arm(3, GATE | ABRT | HWEN | IHWO, 32'h64, `END_RST);
      pins.step(0, 3);
      rreg(3, `OFF_COUNT, 32'h0);
      pins.gate(1'b1);
      chk(32'(irq_cnt[3]), 32'h1);
      pins.step(0, 3);
      pins.step(2, 0);
      rreg(3, `OFF_LATCH - 8'h60, 32'h65);
      pins.gate(1'b0);
      pins.step(0, 3);
      rreg(3, `OFF_COUNT, 32'h65);
      arm(3, GATE | ABRT, 32'h64, `END_RST);
      pins.step(0, 3);
      rreg(3, `OFF_COUNT, 32'h65);
      rreg(3, `OFF_LATCH - 8'h60, 32'h65);
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      n_fail = 0;
      checks = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_bus();
      t_cont();
      t_once_period();
      t_dir();
      t_gate();
      t_ctr3();
      end_of_test();
   end
endmodule
bind updown_counter_bank ctr_checker u_chk (.clk(clk), .rst_n(rst_n), .cmp_out(cmp_out),
   .irq_req(irq_req), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// [pkg/updown_counter_regs.vh]
// register map, field positions and limits of the four up/down counters
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef UPDOWN_COUNTER_REGS_VH
`define UPDOWN_COUNTER_REGS_VH

// counter n sits at n * stride, latch register above the four banks
`define CTR_STRIDE 8'h20
`define OFF_CTRL 5'h00
`define OFF_LOAD 5'h04
`define OFF_END 5'h08
`define OFF_CMP 5'h0C
`define OFF_COUNT 5'h10
`define OFF_STATUS 5'h14
`define OFF_LATCH 8'h80

// control word fields
`define CTRL_SW_GATE 0
`define CTRL_MODE_LO 1
`define CTRL_DIR_LO 3
`define CTRL_ABORT 5
`define CTRL_HW_EN 6
`define CTRL_IE_OVF 7
`define CTRL_IE_UNF 8
`define CTRL_IE_CMP 9
`define CTRL_IE_HWO 10
`define CTRL_IE_HWC 11
`define CTRL_CMP_LO 12
`define CTRL_MASK 32'h00003FFF

`define MODE_CONT 2'h0
`define MODE_ONCE 2'h1
`define MODE_PERIOD 2'h2
`define DIR_NONE 2'h0
`define DIR_FWD 2'h1
`define DIR_BWD 2'h2
`define CMP_NONE 2'h0
`define CMP_GE 2'h1
`define CMP_LE 2'h2

// status word fields; writing a 1 to STS_CLR is the status clear command
`define STS_OVF 0
`define STS_UNF 1
`define STS_MATCH 2
`define STS_RUN 3
`define STS_AUTO 4
`define STS_CLR 0

// count limits and reset values
`define LIMIT_MAX 32'h7FFFFFFF
`define LIMIT_MIN 32'h80000000
`define CTRL_RST 32'h00000000
`define LOAD_RST 32'h00000000
`define END_RST 32'h7FFFFFFF
`define CMP_RST 32'h00000000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/updown_counter_bank.v]
// four 32-bit signed up/down counters with gate, comparator and sticky flags
// counter 3 adds a hardware gate and a latch register
// assumes asynchronous field pins and an AXI4-Lite master on clk
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "updown_counter_regs.vh"
`default_nettype none

module updown_counter_bank #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // field pins
   input wire [3:0] count_up_pin,
   input wire [3:0] count_down_pin,
   input wire hw_gate_pin,
   input wire latch_pin,
   // counter outputs
   output reg [3:0] cmp_out,
   output reg [3:0] irq_req,
   // axi4-lite write address and data
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // one count step: {overflow, underflow, auto close, next value}
   function [34:0] step;
      input [31:0] c;
      input [31:0] ld;
      input [31:0] ev;
      input [31:0] cw;
      input up;
      reg [1:0] md;
      reg [1:0] dr;
      reg [31:0] e;
      begin
         md = cw[`CTRL_MODE_LO +: 2];
         dr = cw[`CTRL_DIR_LO +: 2];
         if (md == `MODE_CONT) begin
            dr = `DIR_NONE;
         end
         e = ev;
         if (dr == `DIR_FWD && ev == `LIMIT_MIN) begin
            e = `LIMIT_MIN + 32'h00000001;
         end
         if (dr == `DIR_BWD && ev == `LIMIT_MAX) begin
            e = `LIMIT_MAX - 32'h00000001;
         end
         step = {3'b000, (up ? c + 32'h00000001 : c - 32'h00000001)};
         if (up && dr == `DIR_FWD && c == e - 32'h00000001) begin
            step = {2'b00, (md == `MODE_ONCE), ld};
         end else if (!up && dr == `DIR_BWD && c == e + 32'h00000001) begin
            step = {2'b00, (md == `MODE_ONCE), ld};
         end else if (up && c == `LIMIT_MAX) begin
            // wrap to the lower limit falls out of the adder
            step[34] = 1'b1;
            step[32] = (md == `MODE_ONCE && dr == `DIR_NONE);
            if (md == `MODE_PERIOD && dr == `DIR_NONE) begin
               step[31:0] = ld;
            end
         end else if (!up && c == `LIMIT_MIN) begin
            step[33] = 1'b1;
            step[32] = (md == `MODE_ONCE && dr == `DIR_NONE);
            if (md == `MODE_PERIOD && dr == `DIR_NONE) begin
               step[31:0] = ld;
            end
         end
      end
   endfunction

   // byte-lane merge of a register write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               merge[b*8 +: 8] = wd[b*8 +: 8];
            end
         end
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers and edge strobes
   // ------------------------------------------------------------
   reg [9:0] pin_s1;
   reg [9:0] pin_s2;
   reg [9:0] pin_s3;
   wire [9:0] pin_rise;
   wire [3:0] up_strobe;
   wire [3:0] down_strobe;
   wire hw_level;
   wire hw_rise;
   wire hw_fall;
   wire latch_rise;

   always @(posedge clk) begin
      if (!rst_n) begin
         pin_s1 <= 10'h000;
         pin_s2 <= 10'h000;
         pin_s3 <= 10'h000;
      end else begin
         pin_s1 <= {latch_pin, hw_gate_pin, count_down_pin, count_up_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   assign pin_rise = pin_s2 & ~pin_s3;
   assign up_strobe = pin_rise[3:0];
   assign down_strobe = pin_rise[7:4];
   assign hw_level = pin_s2[8];
   assign hw_rise = pin_rise[8];
   assign hw_fall = ~pin_s2[8] & pin_s3[8];
   assign latch_rise = pin_rise[9];

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   reg [31:0] ctrl [0:3];
   reg [31:0] load_val [0:3];
   reg [31:0] end_val [0:3];
   reg [31:0] cmp_val [0:3];
   reg [31:0] count [0:3];
   reg [31:0] captured_count;
   reg [3:0] status_clear_cmd;
   reg [3:0] run;
   reg [3:0] auto_closed;
   reg [3:0] overflow_flag;
   reg [3:0] underflow_flag;
   reg [3:0] compare_flag;
   reg [3:0] gate_prev;
   reg [3:0] cond_prev;
   reg sw3_prev;
   reg hw_seen;

   // ------------------------------------------------------------
   // gate decode and step evaluation
   // ------------------------------------------------------------
   reg [3:0] gate_lvl;
   reg [3:0] open_ev;
   reg [3:0] reload_ev;
   reg [3:0] step_en;
   reg [3:0] cond;
   reg [34:0] stp [0:3];
   reg sw3_rise;
   reg hw_on;
   integer k;

   always @* begin
      hw_on = ctrl[3][`CTRL_HW_EN];
      sw3_rise = ctrl[3][`CTRL_SW_GATE] & ~sw3_prev;
      for (k = 0; k < 4; k = k + 1) begin
         gate_lvl[k] = ctrl[k][`CTRL_SW_GATE];
         if (k == 3) begin
            gate_lvl[k] = ctrl[3][`CTRL_SW_GATE] & (hw_level | ~hw_on);
         end
         open_ev[k] = gate_lvl[k] & ~gate_prev[k];
         if (k == 3 && hw_on && auto_closed[3]) begin
            open_ev[k] = gate_lvl[k] & ((hw_rise & ctrl[3][`CTRL_SW_GATE]) |
                                        (sw3_rise & hw_seen));
         end
         reload_ev[k] = ctrl[k][`CTRL_ABORT] & (k != 3 || !hw_on || hw_rise);
         step_en[k] = run[k] & gate_lvl[k] & ~open_ev[k] & (up_strobe[k] ^ down_strobe[k]);
         stp[k] = step(count[k], load_val[k], end_val[k], ctrl[k], up_strobe[k]);
         case (ctrl[k][`CTRL_CMP_LO +: 2])
            `CMP_GE: cond[k] = $signed(count[k]) >= $signed(cmp_val[k]);
            `CMP_LE: cond[k] = $signed(count[k]) <= $signed(cmp_val[k]);
            default: cond[k] = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // counter cores
   // ------------------------------------------------------------
   integer i;

   always @(posedge clk) begin
      if (!rst_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            count[i] <= `LOAD_RST;
         end
         run <= 4'h0;
         auto_closed <= 4'h0;
         overflow_flag <= 4'h0;
         underflow_flag <= 4'h0;
         compare_flag <= 4'h0;
         gate_prev <= 4'h0;
         cond_prev <= 4'h0;
         sw3_prev <= 1'b0;
         hw_seen <= 1'b0;
         captured_count <= 32'h00000000;
         cmp_out <= 4'h0;
         irq_req <= 4'h0;
      end else begin
         gate_prev <= gate_lvl;
         cond_prev <= cond;
         sw3_prev <= ctrl[3][`CTRL_SW_GATE];
         cmp_out <= cond;
         for (i = 0; i < 4; i = i + 1) begin
            if (!gate_lvl[i]) begin
               run[i] <= 1'b0;
            end else if (open_ev[i]) begin
               run[i] <= 1'b1;
               auto_closed[i] <= 1'b0;
               if (reload_ev[i]) begin
                  count[i] <= load_val[i];
               end
            end else if (step_en[i]) begin
               count[i] <= stp[i][31:0];
               if (stp[i][32]) begin
                  run[i] <= 1'b0;
                  auto_closed[i] <= 1'b1;
               end
            end
            // the set wins over a clear arriving in the same cycle
            overflow_flag[i] <= (overflow_flag[i] & ~status_clear_cmd[i]) |
                                (step_en[i] & stp[i][34]);
            underflow_flag[i] <= (underflow_flag[i] & ~status_clear_cmd[i]) |
                                 (step_en[i] & stp[i][33]);
            compare_flag[i] <= (compare_flag[i] & ~status_clear_cmd[i]) | cond[i];
            irq_req[i] <= (step_en[i] & stp[i][34] & ctrl[i][`CTRL_IE_OVF]) |
                          (step_en[i] & stp[i][33] & ctrl[i][`CTRL_IE_UNF]) |
                          (cond[i] & ~cond_prev[i] & ctrl[i][`CTRL_IE_CMP]);
         end
         if (hw_on && ctrl[3][`CTRL_SW_GATE] &&
             ((hw_rise && ctrl[3][`CTRL_IE_HWO]) || (hw_fall && ctrl[3][`CTRL_IE_HWC]))) begin
            irq_req[3] <= 1'b1;
         end
         if (open_ev[3]) begin
            hw_seen <= 1'b0;
         end else if (hw_rise && auto_closed[3]) begin
            hw_seen <= 1'b1;
         end
         if (latch_rise && run[3]) begin
            captured_count <= count[3];
         end
      end
   end

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   wire w_take;
   wire w_bank;
   wire [1:0] w_idx;
   wire [4:0] w_off;
   integer j;

   assign w_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   assign w_bank = ~s_axi_awaddr[7] & (s_axi_awaddr[1:0] == 2'h0);
   assign w_idx = s_axi_awaddr[6:5];
   assign w_off = s_axi_awaddr[4:0];

   always @(posedge clk) begin
      if (!rst_n) begin
         for (j = 0; j < 4; j = j + 1) begin
            ctrl[j] <= `CTRL_RST;
            load_val[j] <= `LOAD_RST;
            end_val[j] <= `END_RST;
            cmp_val[j] <= `CMP_RST;
         end
         status_clear_cmd <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         status_clear_cmd <= 4'h0;
         s_axi_awready <= w_take;
         s_axi_wready <= w_take;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (w_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (!w_bank) begin
               s_axi_bresp <= `RESP_SLVERR;
            end else begin
               case (w_off)
                  `OFF_CTRL: ctrl[w_idx] <= merge(ctrl[w_idx], s_axi_wdata, s_axi_wstrb) &
                                            `CTRL_MASK;
                  `OFF_LOAD: load_val[w_idx] <= merge(load_val[w_idx], s_axi_wdata, s_axi_wstrb);
                  `OFF_END: end_val[w_idx] <= merge(end_val[w_idx], s_axi_wdata, s_axi_wstrb);
                  `OFF_CMP: cmp_val[w_idx] <= merge(cmp_val[w_idx], s_axi_wdata, s_axi_wstrb);
                  `OFF_COUNT: s_axi_bresp <= `RESP_OKAY;
                  `OFF_STATUS: status_clear_cmd[w_idx] <= s_axi_wstrb[0] &
                                                          s_axi_wdata[`STS_CLR];
                  default: s_axi_bresp <= `RESP_SLVERR;
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   wire r_take;
   wire [1:0] r_idx;
   reg [31:0] r_data;
   reg r_ok;

   assign r_take = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
   assign r_idx = s_axi_araddr[6:5];

   always @* begin
      r_data = 32'h00000000;
      r_ok = 1'b1;
      if (s_axi_araddr == `OFF_LATCH) begin
         r_data = captured_count;
      end else if (s_axi_araddr[7] || s_axi_araddr[1:0] != 2'h0) begin
         r_ok = 1'b0;
      end else begin
         case (s_axi_araddr[4:0])
            `OFF_CTRL: r_data = ctrl[r_idx];
            `OFF_LOAD: r_data = load_val[r_idx];
            `OFF_END: r_data = end_val[r_idx];
            `OFF_CMP: r_data = cmp_val[r_idx];
            `OFF_COUNT: r_data = count[r_idx];
            `OFF_STATUS: begin
               r_data[`STS_OVF] = overflow_flag[r_idx];
               r_data[`STS_UNF] = underflow_flag[r_idx];
               r_data[`STS_MATCH] = compare_flag[r_idx];
               r_data[`STS_RUN] = run[r_idx];
               r_data[`STS_AUTO] = auto_closed[r_idx];
            end
            default: r_ok = 1'b0;
         endcase
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= r_take;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (r_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= r_data;
            s_axi_rresp <= r_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

endmodule

`default_nettype wire
